// [verilog/insn_decode_defines.vh]
`ifndef INSN_DECODE_DEFINES_VH
`define INSN_DECODE_DEFINES_VH

// Word and field geometry
`define WORD_W          14
`define FILE_ADDR_W     7
`define BIT_IDX_W       3
`define LIT8_W          8
`define LIT9_W          9
`define LIT11_W         11
`define OSC_PER_CYCLE   4
`define PHASE_LAST      2'h3
`define PHASE_READ      2'h1
`define PHASE_WRITE     2'h3

// Instruction classes
`define CLASS_NONE      2'h0
`define CLASS_BYTE      2'h1
`define CLASS_BIT       2'h2
`define CLASS_LITCTL    2'h3

// Full-word opcodes of the operand-less control group
`define OP_RETURN       14'h0008
`define OP_INT_EXIT     14'h0009
`define OP_ACC_CALL     14'h000A
`define OP_ACC_JUMP     14'h000B

// Opcode prefixes, matched on the upper bits only
`define PFX_CLASS_BYTE  2'h0
`define PFX_CLASS_BIT   2'h1
`define PFX_DEC_SKIP    6'h0B
`define PFX_INC_SKIP    6'h0F
`define PFX_BIT_SKIP0   4'h6
`define PFX_BIT_SKIP1   4'h7
`define PFX_CALL        3'h4
`define PFX_ABS_JUMP    3'h5
`define PFX_REL_JUMP    5'h19
`define PFX_EXIT_LIT    6'h34
`define PFX_PTR_STEP    10'h001
`define PFX_PTR_OFFS    7'h7E
`define PFX_CTL_LOW     7'h00
`define PFX_CLEAR_ACC   7'h02

// Bank-relative addresses of the two indirect access ports
`define INDIRECT_PORT0  7'h00
`define INDIRECT_PORT1  7'h01

`endif

// [verilog/quarter_phase.v]
`include "insn_decode_defines.vh"
`default_nettype none

// Splits the oscillator into four phases per instruction cycle
module quarter_phase (
	input  wire       clock,
	input  wire       sys_rst,
	output wire [1:0] phase,
	output wire       cycle_end
);

	reg [1:0] phase_q;

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	assign phase     = phase_q;
	assign cycle_end = (phase_q == `PHASE_LAST);

endmodule

`default_nettype wire

// [verilog/insn_decode_timing.v]
`include "insn_decode_defines.vh"
`default_nettype none

module insn_decode_timing #(
	parameter WORD_W = `WORD_W
) (
	input  wire              clock,
	input  wire              sys_rst,
	input  wire [WORD_W-1:0] insn_word,
	input  wire              insn_valid,
	output wire              insn_ready,
	input  wire [1:0]        pointer_in_prog_mem,
	input  wire              skip_cond,
	output wire [1:0]        phase,
	output reg  [1:0]        insn_class_q,
	output reg  [6:0]        file_addr_q,
	output reg  [2:0]        bit_index_q,
	output reg  [7:0]        bit_mask_q,
	output reg  [7:0]        lit8_q,
	output reg  [8:0]        lit9_q,
	output reg  [10:0]       lit11_q,
	output reg               dest_is_file_q,
	output reg               pointer_sel_q,
	output reg  [1:0]        step_mode_q,
	output reg               is_call_q,
	output reg               is_return_q,
	output reg               is_jump_q,
	output reg               is_skip_q,
	output reg               is_ptr_step_q,
	output reg               names_file_q,
	output reg  [1:0]        cycles_q,
	output wire              file_read_en,
	output wire              file_write_en,
	output wire              acc_write_en,
	output wire              insn_done
);

	////////////////////////////////////////////////////////////////////////
	// Field and opcode decoding

	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	wire       cycle_end;
	wire [1:0] cls_d;
	wire       call_d;
	wire       ret_d;
	wire       jump_d;
	wire       skip_d;
	wire       step_d;
	wire       offs_d;
	wire       file_d;
	wire       ptr_d;
	wire       indirect_d;
	wire [1:0] base_d;
	wire       ctl_low_d;
	wire       clear_acc_d;

	quarter_phase u_phase (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.phase     (phase),
		.cycle_end (cycle_end)
	);

	// Words below the first file-naming form are operand-less control or pointer forms
	assign ctl_low_d   = (insn_word[13:7] == `PFX_CTL_LOW);
	// The accumulator clear lives in the byte space yet names no file
	assign clear_acc_d = (insn_word[13:7] == `PFX_CLEAR_ACC);

	// Top two bits pick the class once the control words are set aside
	assign cls_d = ctl_low_d                             ? `CLASS_LITCTL :
	               (insn_word[13:12] == `PFX_CLASS_BYTE) ? `CLASS_BYTE   :
	               (insn_word[13:12] == `PFX_CLASS_BIT)  ? `CLASS_BIT    :
	                                                       `CLASS_LITCTL;

	assign call_d = (insn_word[13:11] == `PFX_CALL) ||
	                (insn_word == `OP_ACC_CALL);
	assign ret_d  = (insn_word == `OP_RETURN) || (insn_word == `OP_INT_EXIT) ||
	                (insn_word[13:8] == `PFX_EXIT_LIT);
	assign jump_d = (insn_word[13:11] == `PFX_ABS_JUMP) ||
	                (insn_word[13:9] == `PFX_REL_JUMP) ||
	                (insn_word == `OP_ACC_JUMP);
	assign skip_d = (insn_word[13:8] == `PFX_DEC_SKIP) ||
	                (insn_word[13:8] == `PFX_INC_SKIP) ||
	                (insn_word[13:10] == `PFX_BIT_SKIP0) ||
	                (insn_word[13:10] == `PFX_BIT_SKIP1);
	assign step_d = (insn_word[13:4] == `PFX_PTR_STEP);
	assign offs_d = (insn_word[13:7] == `PFX_PTR_OFFS);

	// Control words drop out by class and the clear by its own match, so its don't-care bits cannot add a cycle
	assign file_d = (cls_d != `CLASS_LITCTL) && !clear_acc_d;

	// Pointer used by pointer forms, or by a direct touch of an indirect port
	assign ptr_d = step_d ? insn_word[2] :
	               offs_d ? insn_word[6] : insn_word[0];
	assign indirect_d = step_d || offs_d ||
	                    (file_d && ((insn_word[6:0] == `INDIRECT_PORT0) ||
	                                (insn_word[6:0] == `INDIRECT_PORT1)));

	// Fixed length known at fetch; a taken skip extends it later
	assign base_d = ((call_d || ret_d || jump_d) ? 2'h2 : 2'h1) +
	                ((indirect_d && pointer_in_prog_mem[ptr_d]) ? 2'h1 : 2'h0);

	////////////////////////////////////////////////////////////////////////
	// Execution sequencing

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg       state_q;
	reg [1:0] cyc_idx_q;
	wire      last_cycle;
	wire      take;
	wire      skip_ext;

	// A taken skip discards the next word, so its first cycle is never the last
	assign skip_ext   = (state_q == ST_EXEC) && is_skip_q && skip_cond &&
	                    (cyc_idx_q == 2'h0);
	assign last_cycle = (cyc_idx_q + 2'h1 >= cycles_q) && !skip_ext;
	assign insn_done  = (state_q == ST_EXEC) && cycle_end && last_cycle;
	// Prefetch overlaps the final phase so back-to-back words lose no cycle
	assign insn_ready = cycle_end && ((state_q == ST_IDLE) || last_cycle);
	assign take       = insn_ready && insn_valid;

	// Read in the second phase, store in the fourth, both in the first cycle
	assign file_read_en  = (state_q == ST_EXEC) && (cyc_idx_q == 2'h0) &&
	                       names_file_q && (phase == `PHASE_READ);
	assign file_write_en = (state_q == ST_EXEC) && (cyc_idx_q == 2'h0) &&
	                       names_file_q && dest_is_file_q &&
	                       (phase == `PHASE_WRITE);
	assign acc_write_en  = (state_q == ST_EXEC) && (cyc_idx_q == 2'h0) &&
	                       names_file_q && !dest_is_file_q &&
	                       (phase == `PHASE_WRITE);

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q        <= ST_IDLE;
			cyc_idx_q      <= 2'h0;
			cycles_q       <= 2'h0;
			insn_class_q   <= `CLASS_NONE;
			file_addr_q    <= 7'h00;
			bit_index_q    <= 3'h0;
			bit_mask_q     <= 8'h00;
			lit8_q         <= 8'h00;
			lit9_q         <= 9'h000;
			lit11_q        <= 11'h000;
			dest_is_file_q <= 1'b0;
			pointer_sel_q  <= 1'b0;
			step_mode_q    <= 2'h0;
			is_call_q      <= 1'b0;
			is_return_q    <= 1'b0;
			is_jump_q      <= 1'b0;
			is_skip_q      <= 1'b0;
			is_ptr_step_q  <= 1'b0;
			names_file_q   <= 1'b0;
		end else begin
			if (take) begin
				state_q        <= ST_EXEC;
				cyc_idx_q      <= 2'h0;
				cycles_q       <= base_d;
				insn_class_q   <= cls_d;
				file_addr_q    <= insn_word[6:0];
				bit_index_q    <= insn_word[9:7];
				bit_mask_q     <= bit_mask(insn_word[9:7]);
				lit8_q         <= insn_word[7:0];
				lit9_q         <= insn_word[8:0];
				lit11_q        <= insn_word[10:0];
				dest_is_file_q <= insn_word[7];
				pointer_sel_q  <= ptr_d;
				step_mode_q    <= insn_word[1:0];
				is_call_q      <= call_d;
				is_return_q    <= ret_d;
				is_jump_q      <= jump_d;
				is_skip_q      <= skip_d;
				is_ptr_step_q  <= step_d;
				names_file_q   <= file_d;
			end else if (state_q == ST_EXEC) begin
				case (state_q)
				ST_EXEC: begin
					if (cycle_end) begin
						if (last_cycle) begin
							state_q <= ST_IDLE;
						end else begin
							cyc_idx_q <= cyc_idx_q + 2'h1;
						end
						// A taken skip discards the next word: one more cycle
						if (skip_ext) begin
							cycles_q <= cycles_q + 2'h1;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// [verification/fetch_model.sv]
`default_nettype none
module fetch_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        insn_ready,
	input  wire logic [1:0]  phase,
	input  wire logic        load,
	input  wire logic [13:0] word_in,
	output var  logic        insn_valid,
	output var  logic [13:0] insn_word,
	output var  logic        taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	assign take = insn_valid && insn_ready && phase == 2'h3;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			insn_valid <= 1'b0;
			insn_word <= 14'h2AAA;
			taken <= 1'b0;
		end else begin
			taken <= take;
			if (load) begin
				insn_valid <= 1'b1;
				insn_word <= word_in;
			end else if (take) begin
				// Released word is inverted so a stale value cannot pass
				insn_valid <= 1'b0;
				insn_word <= ~insn_word;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/insn_decode_checker.sv]
`default_nettype none
module decode_checker (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       insn_valid,
	input wire logic       insn_ready,
	input wire logic [1:0] phase,
	input wire logic [1:0] insn_class_q,
	input wire logic [2:0] bit_index_q,
	input wire logic [7:0] bit_mask_q,
	input wire logic       dest_is_file_q,
	input wire logic       is_skip_q,
	input wire logic       skip_cond,
	input wire logic [1:0] cycles_q,
	input wire logic       file_read_en,
	input wire logic       file_write_en,
	input wire logic       acc_write_en,
	input wire logic       insn_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence take;
		phase == 2'h3 && insn_ready && insn_valid;
	endsequence
	sequence quarter_walk;
		phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0;
	endsequence
	sequence skip_taken;
		take ##1 (cycles_q == 2'h1 && is_skip_q) ##3 skip_cond;
	endsequence
	// Sampled reset keeps the release edge, where phase is still held, out of the walk
	a_phase_walk: assert property (phase == 2'h0 && !sys_rst |=> quarter_walk)
		else $error("phase walk broken");
	a_ready_phase: assert property (insn_ready |-> phase == 2'h3)
		else $error("ready outside last phase");
	a_one_cycle: assert property (take ##1 (cycles_q == 2'h1 && !is_skip_q)
		|-> !insn_done[*3] ##1 insn_done) else $error("single cycle length wrong");
	a_two_cycle: assert property (take ##1 (cycles_q == 2'h2 && !is_skip_q)
		|-> !insn_done[*7] ##1 insn_done) else $error("double cycle length wrong");
	a_skip_extend: assert property (skip_taken |-> !insn_done[*4] ##1 insn_done)
		else $error("taken skip length wrong");
	a_done_ready: assert property (insn_done |-> insn_ready)
		else $error("done without ready");
	a_read_phase: assert property (file_read_en |-> phase == 2'h1)
		else $error("read in wrong phase");
	a_read_then_write: assert property (file_write_en || acc_write_en
		|-> $past(file_read_en, 2)) else $error("store without prior read");
	a_dest_route: assert property (file_write_en || acc_write_en
		|-> file_write_en == dest_is_file_q && !(file_write_en && acc_write_en))
		else $error("destination routing wrong");
	a_bit_mask: assert property (insn_class_q == 2'h2
		|-> bit_mask_q == 8'h01 << bit_index_q) else $error("bit mask wrong");
endmodule
bind insn_decode_timing decode_checker u_decode_checker (
	.clock, .sys_rst, .insn_valid, .insn_ready, .phase, .insn_class_q, .bit_index_q,
	.bit_mask_q, .dest_is_file_q, .is_skip_q, .skip_cond, .cycles_q, .file_read_en, .file_write_en,
	.acc_write_en, .insn_done
);
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        load = 1'b0;
	logic        skip_cond = 1'b0;
	logic [1:0]  pointer_in_prog_mem = 2'h0;
	logic [13:0] word_in = 14'h0000;
	logic [13:0] insn_word;
	logic [10:0] lit11_q;
	logic [8:0]  lit9_q;
	logic [7:0]  lit8_q, bit_mask_q;
	logic [6:0]  file_addr_q;
	logic [2:0]  bit_index_q;
	logic [1:0]  phase, insn_class_q, step_mode_q, cycles_q;
	logic        is_call_q, is_return_q, is_jump_q, is_skip_q, is_ptr_step_q, names_file_q;
	logic        insn_valid, insn_ready, taken, insn_done, dest_is_file_q, pointer_sel_q;
	int          mismatches = 0;
	int          total_checks = 0;
	int          cyc = 0;
	fetch_model u_fetch_model (.clock, .sys_rst, .insn_ready, .phase, .load, .word_in,
		.insn_valid, .insn_word, .taken);
	insn_decode_timing u_insn_decode_timing (.clock, .sys_rst, .insn_word, .insn_valid,
		.insn_ready, .pointer_in_prog_mem, .skip_cond, .phase, .insn_class_q, .file_addr_q,
		.bit_index_q, .bit_mask_q, .lit8_q, .lit9_q, .lit11_q, .dest_is_file_q,
		.pointer_sel_q, .step_mode_q, .is_call_q, .is_return_q, .is_jump_q,
		.is_skip_q, .is_ptr_step_q, .names_file_q, .cycles_q, .file_read_en(),
		.file_write_en(), .acc_write_en(), .insn_done);
	initial forever #12.5 clock = ~clock;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Returns just after the take edge, while the fresh decode is standing
	task automatic issue(input logic [13:0] w);
		int n = 0;
		@(posedge clock);
		load <= 1'b1;
		word_in <= w;
		@(posedge clock);
		load <= 1'b0;
		while (taken !== 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
	endtask
	// Clocks from take to done: four per instruction cycle, less one
	task automatic span(input logic [15:0] exp);
		logic [15:0] n = 16'h0000;
		while (insn_done !== 1'b1 && n < 16'h0010) begin
			@(negedge clock);
			n++;
		end
		check(n, exp);
	endtask
	task automatic t_fields;
		issue(14'h07A5);
		check(insn_class_q, 2'h1);
		check(file_addr_q, 7'h25);
		check(dest_is_file_q, 1'b1);
		check(names_file_q, 1'b1);
		span(16'h3);
		issue(14'h0725);
		check(dest_is_file_q, 1'b0);
		span(16'h3);
		issue(14'h16FF);
		check(insn_class_q, 2'h2);
		check(bit_index_q, 3'h5);
		check(bit_mask_q, 8'h20);
		check(file_addr_q, 7'h7F);
		span(16'h3);
		// Both pointers in program memory, so a decoded don't-care bit would add a cycle
		@(posedge clock);
		pointer_in_prog_mem <= 2'h3;
		for (int i = 0; i < 2; i++) begin
			issue(i[0] ? 14'h0103 : 14'h0100);
			check(insn_class_q, 2'h1);
			check(names_file_q, 1'b0);
			span(16'h3);
		end
		@(posedge clock);
		pointer_in_prog_mem <= 2'h0;
		$display("fields done");
	endtask
	task automatic t_flow;
		logic [13:0] w [8] = '{14'h2123, 14'h000A, 14'h0008, 14'h3455, 14'h0009, 14'h2ABC,
			14'h3321, 14'h000B};
		for (int i = 0; i < 8; i++) begin
			issue(w[i]);
			check(insn_class_q, 2'h3);
			check(lit11_q, w[i][10:0]);
			check(lit8_q, w[i][7:0]);
			check(lit9_q, w[i][8:0]);
			check(is_call_q, i < 2);
			check(is_return_q, i > 1 && i < 5);
			check(is_jump_q, i > 4);
			check(cycles_q, 2'h2);
			span(16'h7);
		end
		$display("flow done");
	endtask
	task automatic t_skip;
		logic [13:0] w [3] = '{14'h0BA0, 14'h0F85, 14'h1A05};
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			skip_cond <= i[0];
			issue(w[i / 2]);
			check(is_skip_q, 1'b1);
			span(i[0] ? 16'h7 : 16'h3);
		end
		@(posedge clock);
		skip_cond <= 1'b0;
		$display("skip done");
	endtask
	task automatic t_ptr;
		logic [1:0] p [3] = '{2'h1, 2'h2, 2'h2};
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			pointer_in_prog_mem <= p[i];
			issue(i == 0 ? 14'h0780 : {13'h03C0, i[1]});
			span(i == 1 ? 16'h3 : 16'h7);
		end
		// Pointer bit differs from bit 0 so a wrong field choice shows; pointer one is in
		// program memory here, so its step forms take the extra cycle
		for (int m = 0; m < 4; m++) begin
			issue({11'h002, !m[0], m[1:0]});
			check(is_ptr_step_q, 1'b1);
			check(step_mode_q, m[1:0]);
			check(pointer_sel_q, !m[0]);
			span(m[0] ? 16'h3 : 16'h7);
		end
		issue(14'h3F44);
		check(pointer_sel_q, 1'b1);
		span(16'h7);
		$display("pointer done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		t_fields();
		t_flow();
		t_skip();
		t_ptr();
		end_sim();
	end
endmodule
`default_nettype wire
